//--- hdl/order_interp.sv
// Display list interpreter for halftone, warp and banded scanline orders.
// Assumes a same-clock word memory port and an external raster unit
// that walks the scanline table and reports each finished specifier.
`timescale 1ns/1ns
module order_interp (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Run control
   input wire logic start,
   input wire logic [27:0] start_ptr,
   output logic busy,
   output logic done,
   output logic [7:0] done_opcode,
   output logic [27:0] done_ptr,
   // Shared memory port
   output logic mem_req,
   output logic mem_we,
   output logic [27:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // Banded map and Boolean state from other order decoders
   input wire logic [7:0] bb_band,
   input wire logic [7:0] bb_direction,
   input wire logic [31:0] bb_phys_logical_offset,
   input wire logic [31:0] bb_eob,
   input wire logic [7:0] bool_dest,
   // Transfer context from other transfer orders
   input wire logic [15:0] xfer_frame_w,
   input wire logic xfer_dest_unbanded,
   // Latched parameters
   output logic [31:0] ht_total,
   output logic [15:0] ht_width,
   output logic [15:0] ht_height,
   output logic [15:0] src_warp_eff,
   output logic [15:0] ub_warp_eff,
   // Raster unit
   output logic raster_start,
   output logic raster_abort,
   output logic raster_b2t,
   output logic [31:0] raster_dest,
   output logic [27:0] raster_table,
   output logic [7:0] raster_bool,
   input wire logic spec_done,
   input wire logic [31:0] spec_resume,
   input wire logic [27:0] spec_next_ptr,
   input wire logic table_end,
   output logic band_fault
);
   typedef struct packed {
      gorder_pkg::state_t st;
      logic [27:0] ptr;
      logic [2:0] widx;
      logic [7:0] op;
      logic [7:0] band;
      logic [15:0] hi;
      logic [31:0] da;
      logic [27:0] scanline_table_pointer;
      logic [31:0] hz;
      logic [15:0] hw;
      logic [15:0] hh;
      logic [15:0] sw;
      logic [15:0] unbanded_dest_warp;
      logic busy;
      logic done;
      logic [7:0] done_op;
      logic [27:0] done_ptr;
      logic mem_req;
      logic mem_we;
      logic [27:0] mem_addr;
      logic [15:0] mem_wdata;
      logic [15:0] src_eff;
      logic [15:0] ub_eff;
      logic r_start;
      logic r_abort;
      logic r_b2t;
      logic [31:0] r_dest;
      logic [27:0] r_table;
      logic [7:0] r_bool;
      logic fault;
   } state_reg_t;

   state_reg_t q;
   state_reg_t d;
   logic [31:0] phys_da;
   logic [31:0] resume_logical;
   logic resume_fault;
   logic b2t;
   logic [2:0] len;

   // Direction taken from the banded map direction byte
   assign b2t = bb_direction[0];

   // Address mapping and band compare
   band_limit u_band_limit (
      .logical_in(q.da),
      .phys_in(spec_resume),
      .phys_logical_offset(bb_phys_logical_offset),
      .end_of_band(bb_eob),
      .b2t(q.r_b2t),
      .phys_out(phys_da),
      .logical_out(resume_logical),
      .fault(resume_fault)
   );

   // Order length from opcode; zero marks a foreign order
   always_comb begin
      case (q.op)
         gorder_pkg::OP_UNBANDED_WARP: len = gorder_pkg::LEN_WARP;
         gorder_pkg::OP_SOURCE_WARP: len = gorder_pkg::LEN_WARP;
         gorder_pkg::OP_HALFTONE_DIMS: len = gorder_pkg::LEN_LONG;
         gorder_pkg::OP_SCAN_BANDED_D: len = gorder_pkg::LEN_LONG;
         default: len = 3'h0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.r_start = 1'b0;
      d.r_abort = 1'b0;
      d.fault = 1'b0;
      d.busy = (q.st != gorder_pkg::ST_IDLE);
      // Warp selection for the transfer currently described
      d.src_eff = (q.sw == gorder_pkg::RST_WORD) ? xfer_frame_w : q.sw;
      d.ub_eff = xfer_dest_unbanded ? q.unbanded_dest_warp : gorder_pkg::RST_WORD;
      case (q.st)
         gorder_pkg::ST_IDLE: begin
            if (start) begin
               d.ptr = start_ptr;
               d.widx = 3'h0;
               d.st = gorder_pkg::ST_FETCH;
               d.busy = 1'b1;
            end
         end
         gorder_pkg::ST_FETCH: begin
            if (!q.mem_req) begin
               d.mem_req = 1'b1;
               d.mem_we = 1'b0;
               d.mem_addr = q.ptr + {24'h00_0000, q.widx, 1'b0};
            end else if (mem_ack) begin
               d.mem_req = 1'b0;
               d.widx = q.widx + 3'h1;
               if (q.widx == 3'h0) begin
                  // Second byte is a band number or ignored
                  d.op = mem_rdata[15:8];
                  d.band = mem_rdata[7:0];
               end else if (q.widx == 3'h1 || q.widx == 3'h3) begin
                  d.hi = mem_rdata;
               end
               // Parameter words by opcode and position
               case (q.op)
                  gorder_pkg::OP_UNBANDED_WARP: if (q.widx == 3'h1) d.unbanded_dest_warp = mem_rdata;
                  gorder_pkg::OP_SOURCE_WARP: if (q.widx == 3'h1) d.sw = mem_rdata;
                  gorder_pkg::OP_HALFTONE_DIMS: begin
                     if (q.widx == 3'h2) d.hz = {q.hi, mem_rdata};
                     if (q.widx == 3'h3) d.hw = mem_rdata;
                     if (q.widx == 3'h4) d.hh = mem_rdata;
                  end
                  gorder_pkg::OP_SCAN_BANDED_D: begin
                     if (q.widx == 3'h2) d.da = {q.hi, mem_rdata};
                     if (q.widx == 3'h4) d.scanline_table_pointer = {q.hi[11:0], mem_rdata};
                  end
                  default: d.hi = q.hi;
               endcase
               if (q.widx != 3'h0 && q.widx + 3'h1 == len) begin
                  d.widx = 3'h0;
                  d.ptr = q.ptr + {24'h00_0000, len, 1'b0};
                  if (q.op == gorder_pkg::OP_SCAN_BANDED_D && q.band == bb_band) begin
                     d.ptr = q.ptr;
                     d.st = gorder_pkg::ST_RUN;
                  end
               end
            end
            // Foreign opcode: hand the list back at this order
            if (q.mem_req == 1'b0 && q.widx == 3'h1 && len == 3'h0) begin
               d.mem_req = 1'b0;
               d.done = 1'b1;
               d.done_op = q.op;
               d.done_ptr = q.ptr;
               d.widx = 3'h0;
               d.st = gorder_pkg::ST_IDLE;
            end
            // Launch the raster walk on entry to the run state
            if (d.st == gorder_pkg::ST_RUN) begin
               d.r_start = 1'b1;
               d.r_b2t = b2t;
               d.r_dest = phys_da;
               d.r_table = d.scanline_table_pointer;
               d.r_bool = bool_dest;
            end
         end
         gorder_pkg::ST_RUN: begin
            if (table_end) begin
               d.ptr = q.ptr + {24'h00_0000, gorder_pkg::LEN_LONG, 1'b0};
               d.st = gorder_pkg::ST_FETCH;
            end else if (spec_done && resume_fault) begin
               // Cut the transfer and prepare the order rewrite
               d.r_abort = 1'b1;
               d.fault = 1'b1;
               d.band = q.r_b2t ? q.band - 8'h01 : q.band + 8'h01;
               d.da = resume_logical;
               d.scanline_table_pointer = spec_next_ptr;
               d.widx = 3'h0;
               d.st = gorder_pkg::ST_WBACK;
            end
         end
         gorder_pkg::ST_WBACK: begin
            // Only the order's own words are written, never the table
            if (!q.mem_req) begin
               d.mem_req = 1'b1;
               d.mem_we = 1'b1;
               d.mem_addr = q.ptr + {24'h00_0000, q.widx, 1'b0};
               case (q.widx)
                  3'h0: d.mem_wdata = {q.op, q.band};
                  3'h1: d.mem_wdata = q.da[31:16];
                  3'h2: d.mem_wdata = q.da[15:0];
                  3'h3: d.mem_wdata = {gorder_pkg::PTR_PAD, q.scanline_table_pointer[27:16]};
                  default: d.mem_wdata = q.scanline_table_pointer[15:0];
               endcase
            end else if (mem_ack) begin
               d.mem_req = 1'b0;
               d.mem_we = 1'b0;
               d.widx = q.widx + 3'h1;
               if (q.widx == 3'h4) begin
                  d.widx = 3'h0;
                  d.ptr = q.ptr + {24'h00_0000, gorder_pkg::LEN_LONG, 1'b0};
                  d.st = gorder_pkg::ST_FETCH;
               end
            end
         end
         default: d.st = gorder_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{st: gorder_pkg::ST_IDLE, ptr: gorder_pkg::RST_ADDR, widx: 3'h0,
                op: gorder_pkg::RST_BYTE, band: gorder_pkg::RST_BYTE, hi: gorder_pkg::RST_WORD,
                da: gorder_pkg::RST_LONG, scanline_table_pointer: gorder_pkg::RST_ADDR, hz: gorder_pkg::RST_LONG,
                hw: gorder_pkg::RST_WORD, hh: gorder_pkg::RST_WORD, sw: gorder_pkg::RST_WORD,
                unbanded_dest_warp: gorder_pkg::RST_WORD, busy: 1'b0, done: 1'b0, done_op: gorder_pkg::RST_BYTE,
                done_ptr: gorder_pkg::RST_ADDR, mem_req: 1'b0, mem_we: 1'b0,
                mem_addr: gorder_pkg::RST_ADDR, mem_wdata: gorder_pkg::RST_WORD,
                src_eff: gorder_pkg::RST_WORD, ub_eff: gorder_pkg::RST_WORD, r_start: 1'b0,
                r_abort: 1'b0, r_b2t: 1'b0, r_dest: gorder_pkg::RST_LONG,
                r_table: gorder_pkg::RST_ADDR, r_bool: gorder_pkg::RST_BYTE, fault: 1'b0};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign busy = q.busy;
   assign done = q.done;
   assign done_opcode = q.done_op;
   assign done_ptr = q.done_ptr;
   assign mem_req = q.mem_req;
   assign mem_we = q.mem_we;
   assign mem_addr = q.mem_addr;
   assign mem_wdata = q.mem_wdata;
   assign ht_total = q.hz;
   assign ht_width = q.hw;
   assign ht_height = q.hh;
   assign src_warp_eff = q.src_eff;
   assign ub_warp_eff = q.ub_eff;
   assign raster_start = q.r_start;
   assign raster_abort = q.r_abort;
   assign raster_b2t = q.r_b2t;
   assign raster_dest = q.r_dest;
   assign raster_table = q.r_table;
   assign raster_bool = q.r_bool;
   assign band_fault = q.fault;
endmodule

//--- include/gorder_pkg.sv
// Shared constants and types for the graphic order interpreter.
// Assumes 16-bit display list words and 28-bit byte addresses.
package gorder_pkg;
   // Opcodes handled by this block
   localparam logic [7:0] OP_UNBANDED_WARP = 8'h09;
   localparam logic [7:0] OP_SOURCE_WARP = 8'h0A;
   localparam logic [7:0] OP_HALFTONE_DIMS = 8'h0B;
   localparam logic [7:0] OP_SCAN_BANDED_D = 8'h34;

   // Order lengths in words, opcode word included
   localparam logic [2:0] LEN_WARP = 3'h2;
   localparam logic [2:0] LEN_LONG = 3'h5;

   // Widths
   localparam int ADDR_W = 28;
   localparam int WORD_W = 16;
   localparam int LONG_W = 32;

   // Reset values of latched parameters and the table pointer pad bits
   localparam logic [31:0] RST_LONG = 32'h0000_0000;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [27:0] RST_ADDR = 28'h000_0000;
   localparam logic [3:0] PTR_PAD = 4'h0;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_RUN,
      ST_WBACK
   } state_t;
endpackage

//--- hdl/band_limit.sv
// Logical/physical address mapping and band fault compare.
// Assumes offset and end of band come from the banded map setup.
`timescale 1ns/1ns
module band_limit (
   // Mapping inputs
   input wire logic [31:0] logical_in,
   input wire logic [31:0] phys_in,
   input wire logic [31:0] phys_logical_offset,
   // Band limit
   input wire logic [31:0] end_of_band,
   input wire logic b2t,
   // Results
   output logic [31:0] phys_out,
   output logic [31:0] logical_out,
   output logic fault
);
   // Both directions of the signed offset mapping
   assign phys_out = logical_in + phys_logical_offset;
   assign logical_out = phys_in - phys_logical_offset;

   // Fault at or past the band end, direction aware
   assign fault = b2t ? (phys_in <= end_of_band) : (phys_in >= end_of_band);
endmodule

//--- testbench/mem_model.sv
// Word store standing in for the shared display list memory.
// Assumes one request at a time, held until acknowledged.
`timescale 1ns/1ns
module mem_model (
   // Clock and answer delay
   input wire logic clk,
   input wire logic [1:0] lat,
   // Memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [27:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] m [0:511];
   logic [1:0] wait_q;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      wait_q = 2'h0;
   end
   // Answer after lat cycles; read data keeps changing while idle
   always @(posedge clk) begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
      end else if (mem_req && wait_q == lat) begin
         mem_ack <= 1'b1;
         if (mem_we) m[mem_addr[9:1]] <= mem_wdata;
         else mem_rdata <= m[mem_addr[9:1]];
      end else if (mem_req) wait_q <= wait_q + 2'h1;
   end
endmodule

//--- testbench/gorder_asserts.sv
// Port checker for the order interpreter.
// Assumes one clock domain; bound onto order_interp.
`timescale 1ns/1ns
module gorder_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Watched ports
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [27:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [7:0] bb_band,
   input wire logic [7:0] bb_direction,
   input wire logic [31:0] bb_eob,
   input wire logic [7:0] bool_dest,
   input wire logic xfer_dest_unbanded,
   input wire logic [15:0] ub_warp_eff,
   input wire logic raster_start,
   input wire logic raster_abort,
   input wire logic raster_b2t,
   input wire logic [27:0] raster_table,
   input wire logic [7:0] raster_bool,
   input wire logic spec_done,
   input wire logic [31:0] spec_resume,
   input wire logic band_fault
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Band fault cause and follow-up
   a_fault_abort: assert property (band_fault |-> raster_abort)
      else $error("fault without abort");
   a_fault_cause: assert property (band_fault |-> $past(spec_done) &&
      (raster_b2t ? $past(spec_resume) <= bb_eob : $past(spec_resume) >= bb_eob)) else $error("bad fault");
   a_band_step: assert property (band_fault |-> ##[1:40] mem_req && mem_we &&
      mem_wdata == {8'h34, raster_b2t ? bb_band - 8'h01 : bb_band + 8'h01}) else $error("band not stepped");
   a_table_ro: assert property (mem_req && mem_we |-> mem_addr != raster_table)
      else $error("table written");
   // Raster start fields and unbanded warp gating
   a_b2t_flag: assert property (raster_start |-> raster_b2t == bb_direction[0])
      else $error("direction wrong");
   a_bool_code: assert property (raster_start |-> raster_bool == bool_dest)
      else $error("boolean code wrong");
   a_ub_zero: assert property (!$past(xfer_dest_unbanded) |-> ub_warp_eff == 16'h0000)
      else $error("unbanded warp leaks");
   // Memory handshake
   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
      $stable(mem_we) && $stable(mem_wdata)) else $error("request moved");
   a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
      else $error("no idle cycle");
   c_fault_down: cover property (band_fault && !raster_b2t);
   c_fault_up: cover property (band_fault && raster_b2t);
   c_start: cover property (raster_start);
endmodule
bind order_interp gorder_asserts i_gorder_asserts (.clk, .arst_n, .mem_req, .mem_we, .mem_addr,
   .mem_wdata, .mem_ack, .bb_band, .bb_direction, .bb_eob, .bool_dest, .xfer_dest_unbanded,
   .ub_warp_eff, .raster_start, .raster_abort, .raster_b2t, .raster_table, .raster_bool,
   .spec_done, .spec_resume, .band_fault);

//--- testbench/test_order_interp.sv
// Self-checking bench for the order interpreter.
// Assumes mem_model holds the list; the raster unit is driven here.
`timescale 1ns/1ns
module test_order_interp;
   logic clk, arst_n, start, busy, done, mem_req, mem_we, mem_ack;
   logic xfer_dest_unbanded, raster_start, raster_abort, raster_b2t, spec_done, table_end, band_fault;
   logic [1:0] lat;
   logic [7:0] done_opcode, bb_band, bb_direction, bool_dest, raster_bool;
   logic [15:0] mem_wdata, mem_rdata, xfer_frame_w, ht_width, ht_height, src_warp_eff, ub_warp_eff, hw, hh, uw;
   logic [27:0] start_ptr, done_ptr, mem_addr, raster_table, spec_next_ptr;
   logic [31:0] bb_phys_logical_offset, bb_eob, ht_total, raster_dest, spec_resume, da, ps, tot;
   logic [15:0] lst [15];
   logic [63:0] e;
   logic [63:0] q [$];
   int n_fail, samples_checked, n_ev;
   localparam logic [63:0] DONE_E = {28'h0, 8'hFF, 28'h000_011C};
   order_interp i_order_interp (.clk, .arst_n, .start, .start_ptr, .busy, .done, .done_opcode, .done_ptr,
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .bb_band, .bb_direction, .bb_phys_logical_offset,
      .bb_eob, .bool_dest, .xfer_frame_w, .xfer_dest_unbanded, .ht_total, .ht_width, .ht_height,
      .src_warp_eff, .ub_warp_eff, .raster_start, .raster_abort, .raster_b2t, .raster_dest, .raster_table,
      .raster_bool, .spec_done, .spec_resume, .spec_next_ptr, .table_end, .band_fault);
   mem_model i_mem_model (.clk, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input string n, input logic [63:0] x, input logic [63:0] g);
      samples_checked++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task final_report;
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function logic [15:0] rd(input logic [27:0] a);
      return i_mem_model.m[a[9:1]];
   endfunction
   task wait_ev(input int k);
      for (int i = 0; i < 3000 && n_ev < k; i++) @(negedge clk);
      if (n_ev < k) begin
         chk("timeout", 64'h0, 64'h1);
         final_report;
      end
   endtask
   task go(input logic [27:0] p);
      repeat (2) @(negedge clk);
      start_ptr = p;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask
   task pulse_spec(input logic [31:0] r, input logic [27:0] np);
      @(negedge clk);
      spec_resume = r;
      spec_next_ptr = np;
      spec_done = 1'b1;
      @(negedge clk);
      spec_done = 1'b0;
   endtask
   // Rewritten order fields and the untouched table
   task check_wb(input logic [15:0] ob, input logic [31:0] r, input logic [27:0] p);
      chk("band", ob, rd(28'h112));
      chk("da", r - ps, {rd(28'h114), rd(28'h116)});
      chk("ptr", {4'h0, p}, {rd(28'h118), rd(28'h11A)});
      for (int j = 0; j < 4; j++) chk("table", 16'hA5A0 + j, rd(28'(256 * 2 + 2 * j)));
   endtask
   // Each raster start or done pulse takes the oldest note, sampled mid-cycle
   always @(negedge clk) begin
      if (raster_start === 1'b1 || done === 1'b1) begin
         n_ev++;
         if (q.size() > 0) e = q.pop_front();
         else e = 'x;
         chk("result", e, raster_start ? {4'h0, raster_table, raster_dest} : {28'h0, done_opcode, done_ptr});
      end
   end
   // Main sequence
   initial begin
      arst_n = 1'b0;
      start = 1'b0;
      start_ptr = '0;
      lat = 2'h0;
      spec_done = 1'b0;
      table_end = 1'b0;
      spec_resume = '0;
      spec_next_ptr = '0;
      bb_band = 8'h05;
      bb_direction = 8'h00;
      bool_dest = 8'h5A;
      n_fail = 0;
      samples_checked = 0;
      n_ev = 0;
      void'($urandom(72));
      hw = 16'($urandom_range(65535, 32));
      hh = 16'($urandom_range(65535, 1));
      tot = 32'(hw) * 32'(hh);
      uw = 16'($urandom);
      da = $urandom;
      ps = $urandom;
      bb_phys_logical_offset = ps;
      bb_eob = 32'h8000_0000;
      xfer_frame_w = 16'($urandom);
      xfer_dest_unbanded = 1'b1;
      // Dims, zero source warp, unbanded warp, scanline, foreign opcode
      lst = '{16'h0B00, tot[31:16], tot[15:0], hw, hh, 16'h0A00, 16'h0000, 16'h09FF, uw,
         16'h3405, da[31:16], da[15:0], 16'h0000, 16'h0200, 16'hFF00};
      for (int i = 0; i < 15; i++) i_mem_model.m[128 + i] = lst[i];
      for (int i = 0; i < 4; i++) i_mem_model.m[256 + i] = 16'hA5A0 + 16'(i);
      repeat (8) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      q.push_back({4'h0, 28'h000_0200, da + ps});
      q.push_back(DONE_E);
      go(28'h000_0100);
      wait_ev(1);
      chk("busy", 1'b1, busy);
      chk("total", tot, ht_total);
      chk("width", hw, ht_width);
      chk("height", hh, ht_height);
      chk("src_warp", xfer_frame_w, src_warp_eff);
      chk("ub_warp", uw, ub_warp_eff);
      xfer_dest_unbanded = 1'b0;
      repeat (2) @(negedge clk);
      chk("ub_off", 16'h0000, ub_warp_eff);
      pulse_spec(32'h9000_0000, 28'h000_0204);
      wait_ev(2);
      check_wb(16'h3406, 32'h9000_0000, 28'h000_0204);
      // Bottom-up pass on the rewritten order
      bb_band = 8'h06;
      bb_direction = 8'h01;
      lat = 2'h2;
      q.push_back({4'h0, 28'h000_0204, 32'h9000_0000});
      q.push_back(DONE_E);
      go(28'h000_0112);
      wait_ev(3);
      pulse_spec(32'h7000_0000, 28'h000_0208);
      wait_ev(4);
      check_wb(16'h3405, 32'h7000_0000, 28'h000_0208);
      // Other band: order skipped
      bb_band = 8'h09;
      q.push_back(DONE_E);
      go(28'h000_0112);
      wait_ev(5);
      // Table runs out without a fault
      bb_band = 8'h05;
      bb_direction = 8'h00;
      lat = 2'h1;
      q.push_back({4'h0, 28'h000_0208, 32'h7000_0000});
      q.push_back(DONE_E);
      go(28'h000_0112);
      wait_ev(6);
      @(negedge clk) table_end = 1'b1;
      @(negedge clk) table_end = 1'b0;
      wait_ev(7);
      check_wb(16'h3405, 32'h7000_0000, 28'h000_0208);
      // Non-zero source warp is kept as given; reserved byte set
      i_mem_model.m[160] = 16'h0A33;
      i_mem_model.m[161] = uw | 16'h0001;
      i_mem_model.m[162] = 16'hFF00;
      q.push_back({28'h0, 8'hFF, 28'h000_0144});
      go(28'h000_0140);
      wait_ev(8);
      chk("src_keep", uw | 16'h0001, src_warp_eff);
      repeat (2) @(negedge clk);
      chk("idle", 1'b0, busy);
      final_report;
   end
endmodule
